// >>> bench/hcr_host_cmd_checker.sv
// assertions on the ports of the command register block
`timescale 1ns/1ps
module hcr_host_cmd_checker #(
  parameter int RESET_CYCLES = 16
) (
  // clock and reset
  input logic        core_clk,
  input logic        rst,
  // register bus
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [11:0] s_axi_araddr,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // core controls
  input logic        runStop_q,
  input logic        coreReset_q,
  input logic        portReset_q,
  input logic        cmdStrobe_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_cap_word: assert property (
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == 12'h008 |-> s_axi_rdata == 32'h0000_0086)
    else $error("capability word wrong");
  a_bad_read: assert property ($rose(s_axi_rvalid)
    && !($past(s_axi_araddr) inside {12'h008, 12'h020})
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_no_accept: assert property (s_axi_bvalid |=> !cmdStrobe_q)
    else $error("write applied while answering");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  a_strobe_cause: assert property (cmdStrobe_q |-> s_axi_bvalid ##1 !cmdStrobe_q)
    else $error("command strobe without write");
  a_reset_len: assert property ($rose(coreReset_q)
    |-> !runStop_q ##RESET_CYCLES coreReset_q ##1 !coreReset_q) else $error("reset length");
  a_port_core: assert property (portReset_q |-> coreReset_q)
    else $error("port reset without core reset");
endmodule : hcr_host_cmd_checker

// >>> bench/hcr_host_cmd_test.sv
// self-checking bench of the command register block
`timescale 1ns/1ps
module hcr_host_cmd_test;
  logic        core_clk = 0, rst = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, frameListSize_q, rs;
  logic        runStop_q, coreReset_q, portReset_q, cmdStrobe_q;
  int          err_count = 0, check_count = 0, strobes = 0;
  hcr_host_cmd #(.RESET_CYCLES(2)) uut (.*);
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (cmdStrobe_q === 1'b1) strobes++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40) err_count++;
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 40) err_count++;
  endtask : rdr
  task automatic t_reset_vals;
    rdr(12'h008);
    chk(rd, 32'h0000_0086);
    rdr(12'h020);
    chk(rd, 32'h0008_0B00);
    chk(runStop_q, 1'b0);
  endtask : t_reset_vals
  task automatic t_cap_write;
    wr(12'h008, 32'hFFFF_FFFF);
    chk(rs, 2'h0);
    rdr(12'h008);
    chk(rd, 32'h0000_0086);
  endtask : t_cap_write
  task automatic t_run;
    wr(12'h020, 32'h0008_0B09);
    #1;
    chk(runStop_q, 1'b1);
    chk(frameListSize_q, 2'h2);
    rdr(12'h020);
    chk(rd, 32'h0008_0B09);
    chk(strobes, 1);
  endtask : t_run
  task automatic t_full;
    wr(12'h020, 32'h0008_0B03);
    #1;
    chk({coreReset_q, portReset_q, runStop_q}, 3'b110);
    repeat (5) @(posedge core_clk);
    rdr(12'h020);
    chk(rd, 32'h0008_0B00);
  endtask : t_full
  task automatic t_light;
    wr(12'h020, 32'h0008_0B81);
    #1;
    chk({coreReset_q, portReset_q, runStop_q}, 3'b100);
    repeat (5) @(posedge core_clk);
    rdr(12'h020);
    chk(rd & 32'h0000_0081, 32'h0);
  endtask : t_light
  task automatic t_unmapped;
    rdr(12'h100);
    chk({rs, rd}, {2'h2, 32'h0});
    wr(12'h104, 32'h0000_0001);
    chk(rs, 2'h2);
  endtask : t_unmapped
  task automatic print_verdict;
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_vals();
    t_cap_write();
    t_run();
    t_full();
    t_light();
    t_unmapped();
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
endmodule : hcr_host_cmd_test
bind hcr_host_cmd hcr_host_cmd_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.*);

// >>> rtl/hcr_host_cmd.sv
// capability parameters and host command registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "hcr_regs.svh"

// Functional notes
// - capability word read-only, reserved bits zero
// - bits 15:8 extended capabilities pointer, zero
// - bits 7:4 iso scheduling threshold 1000
// - bit 2 async park supported, one
// - flag one: honour programmed frame list size
// - command write starts command execution
// - bit 7 light reset: core only
// - light reset absent: bit 7 reads zero
// - bit 1 resets whole controller
// - bit 0 run/stop, resets to zero
module hcr_host_cmd #(
  parameter logic [7:0] EXT_CAPS_PTR    = `HCR_EXT_CAPS_PTR,
  parameter logic [3:0] ISO_THRESH      = `HCR_ISO_THRESH,
  parameter logic       ASYNC_PARK      = `HCR_ASYNC_PARK,
  parameter logic       PROG_FRAME_LIST = `HCR_PROG_FRAME_LIST,
  parameter logic       LIGHT_RESET_EN  = `HCR_LIGHT_RESET_EN,
  parameter int         RESET_CYCLES    = `HCR_RESET_CYCLES
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // AXI4-Lite write address
  input  wire logic [`HCR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [`HCR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // controller core controls
  output logic                        runStop_q,
  output logic [1:0]                  frameListSize_q,
  output logic                        coreReset_q,
  output logic                        portReset_q,
  output logic                        cmdStrobe_q
);

  // register word select, ignoring byte offset
  function automatic logic regHit(input logic [`HCR_ADDR_W-1:0] addr,
                                  input logic [`HCR_ADDR_W-1:0] ofs);
    regHit = (addr[`HCR_ADDR_W-1:2] == ofs[`HCR_ADDR_W-1:2]);
  endfunction : regHit

  // byte-lane merge of write data into an old word
  function automatic logic [31:0] laneMerge(input logic [31:0] oldWord,
                                            input logic [31:0] newWord,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = oldWord;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = newWord[8*i +: 8];
      end
    end
    laneMerge = res;
  endfunction : laneMerge

  // capability word, constant
  hcr_pkg::hcr_cap_s capWord;
  assign capWord.rsvdHigh                  = '0;
  assign capWord.extCapsPointer            = EXT_CAPS_PTR;
  assign capWord.isoSchedThreshold         = ISO_THRESH;
  assign capWord.rsvdBit3                  = 1'b0;
  assign capWord.asyncParkCapable          = ASYNC_PARK;
  assign capWord.programmableFrameListFlag = PROG_FRAME_LIST;
  assign capWord.rsvdBit0                  = 1'b0;

  // bus channel state
  logic                  awHeld_q;
  logic                  wHeld_q;
  hcr_pkg::hcr_wreq_s    wreq_q;
  hcr_pkg::hcr_cmd_s     cmd_q;
  hcr_pkg::hcr_cmd_s     cmd_d;

  wire awTake  = s_axi_awvalid && s_axi_awready;
  wire wTake   = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  wire arTake  = s_axi_arvalid && s_axi_arready;

  wire awHeld_d = doWrite ? 1'b0 : (awTake ? 1'b1 : awHeld_q);
  wire wHeld_d  = doWrite ? 1'b0 : (wTake ? 1'b1 : wHeld_q);
  wire bValid_d = doWrite ? 1'b1 : (s_axi_bready ? 1'b0 : s_axi_bvalid);
  wire rValid_d = arTake ? 1'b1 : (s_axi_rready ? 1'b0 : s_axi_rvalid);

  // write decode
  wire wrCap = regHit(wreq_q.addr, `HCR_CAP_PARAMS_OFS);
  wire wrCmd = regHit(wreq_q.addr, `HCR_HOST_CMD_OFS);
  wire [1:0] wrResp = (wrCap || wrCmd) ? `HCR_RESP_OKAY : `HCR_RESP_SLVERR;

  // reset sequencers
  logic fullBusy;
  logic fullDone;
  logic lightBusy;
  logic lightDone;

  // a write during a full reset is acknowledged but not applied
  wire cmdWr = doWrite && wrCmd && !fullBusy;
  hcr_pkg::hcr_cmd_s wrWord;
  assign wrWord = hcr_pkg::hcr_cmd_s'(laneMerge(cmd_q, wreq_q.data, wreq_q.strb));

  wire fullStart  = cmdWr && wrWord.fullControllerReset;
  wire lightStart = LIGHT_RESET_EN && cmdWr && !fullStart
                    && wrWord.lightCoreReset && !lightBusy;

  // next command word
  always_comb begin
    cmd_d = cmd_q;
    if (fullDone) begin
      cmd_d = hcr_pkg::hcr_cmd_s'(`HCR_CMD_RESET);
    end else if (cmdWr) begin
      cmd_d = wrWord;
      if (!PROG_FRAME_LIST) begin
        cmd_d.frameListSize = `HCR_FLS_1024;
      end
      cmd_d.fullControllerReset = fullStart;
      cmd_d.lightCoreReset = LIGHT_RESET_EN
                             && (lightStart || (lightBusy && !lightDone));
      if (fullStart || lightStart) begin
        cmd_d.runStop = 1'b0;
      end
    end else if (lightDone) begin
      cmd_d.lightCoreReset = 1'b0;
    end
  end

  // read decode
  wire rdCap = regHit(s_axi_araddr, `HCR_CAP_PARAMS_OFS);
  wire rdCmd = regHit(s_axi_araddr, `HCR_HOST_CMD_OFS);
  wire [31:0] rdWord = rdCap ? 32'(capWord) : (rdCmd ? 32'(cmd_q) : 32'h0000_0000);
  wire [1:0]  rdResp = (rdCap || rdCmd) ? `HCR_RESP_OKAY : `HCR_RESP_SLVERR;

  hcr_reset_seq #(
    .CYCLES (RESET_CYCLES)
  ) u_full_seq (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (fullStart),
    .busy_q   (fullBusy),
    .done_q   (fullDone)
  );

  hcr_reset_seq #(
    .CYCLES (RESET_CYCLES)
  ) u_light_seq (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (lightStart),
    .busy_q   (lightBusy),
    .done_q   (lightDone)
  );

  // write channels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      wreq_q        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `HCR_RESP_OKAY;
    end else begin
      awHeld_q      <= awHeld_d;
      wHeld_q       <= wHeld_d;
      s_axi_awready <= !awHeld_d;
      s_axi_wready  <= !wHeld_d;
      s_axi_bvalid  <= bValid_d;
      if (awTake) begin
        wreq_q.addr <= s_axi_awaddr;
      end
      if (wTake) begin
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bresp <= wrResp;
      end
    end
  end

  // read channels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `HCR_RESP_OKAY;
    end else begin
      s_axi_arready <= !rValid_d;
      s_axi_rvalid  <= rValid_d;
      if (arTake) begin
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdResp;
      end
    end
  end

  // command register and core controls
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_q           <= hcr_pkg::hcr_cmd_s'(`HCR_CMD_RESET);
      runStop_q       <= 1'b0;
      frameListSize_q <= `HCR_FLS_1024;
      coreReset_q     <= 1'b0;
      portReset_q     <= 1'b0;
      cmdStrobe_q     <= 1'b0;
    end else begin
      cmd_q           <= cmd_d;
      runStop_q       <= cmd_d.runStop;
      frameListSize_q <= cmd_d.frameListSize;
      coreReset_q     <= fullBusy || lightBusy || fullStart || lightStart;
      portReset_q     <= fullBusy || fullStart;
      cmdStrobe_q     <= cmdWr;
    end
  end

endmodule : hcr_host_cmd

// >>> rtl/hcr_pkg.sv
// types of the capability and command register block
package hcr_pkg;

  // host_command layout
  typedef struct packed {
    logic [23:0] rsvdHigh;
    logic        lightCoreReset;
    logic [2:0]  rsvdMid;
    logic [1:0]  frameListSize;
    logic        fullControllerReset;
    logic        runStop;
  } hcr_cmd_s;

  // capability_parameters layout
  typedef struct packed {
    logic [15:0] rsvdHigh;
    logic [7:0]  extCapsPointer;
    logic [3:0]  isoSchedThreshold;
    logic        rsvdBit3;
    logic        asyncParkCapable;
    logic        programmableFrameListFlag;
    logic        rsvdBit0;
  } hcr_cap_s;

  // write request held between the address and data channels
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } hcr_wreq_s;

endpackage : hcr_pkg

// >>> rtl/hcr_regs.svh
// offsets, reset values and counts of the capability and command registers
`ifndef HCR_REGS_SVH
`define HCR_REGS_SVH

// register map, byte addresses
`define HCR_ADDR_W          12
`define HCR_CAP_PARAMS_OFS  12'h008
`define HCR_HOST_CMD_OFS    12'h020

// capability_parameters field values
`define HCR_EXT_CAPS_PTR    8'h00
`define HCR_ISO_THRESH      4'h8
`define HCR_ASYNC_PARK      1'b1
`define HCR_PROG_FRAME_LIST 1'b1

// host_command reset value and frame list size code for 1024 entries
`define HCR_CMD_RESET       32'h0008_0B00
`define HCR_FLS_1024        2'h0

// length of the core reset sequence, in core_clk cycles
`define HCR_RESET_CYCLES    16

// light reset present by default
`define HCR_LIGHT_RESET_EN  1'b1

// AXI4-Lite response codes
`define HCR_RESP_OKAY       2'h0
`define HCR_RESP_SLVERR     2'h2

`endif

// >>> rtl/hcr_reset_seq.sv
// timed reset sequence: busy level for a fixed count, then a done pulse
`timescale 1ns/1ps
`include "hcr_regs.svh"

module hcr_reset_seq #(
  parameter int CYCLES = `HCR_RESET_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  // status
  output logic      busy_q,
  output logic      done_q
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_q;
  wire           lastCount = busy_q && (count_q == CW'(1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      count_q <= '0;
    end else begin
      done_q <= lastCount;
      if (start && !busy_q) begin
        busy_q  <= 1'b1;
        count_q <= CW'(CYCLES);
      end else if (lastCount) begin
        busy_q  <= 1'b0;
        count_q <= '0;
      end else if (busy_q) begin
        count_q <= count_q - CW'(1);
      end
    end
  end

endmodule : hcr_reset_seq
